/* design/change_latch.v */
`timescale 1ns/10ps
`include "status_change_defines.vh"

// one edge-capture register with its own enable mask
module change_latch (
    // clock and reset
    input wire clk,
    input wire rst,
    // state word, current and previous cycle
    input wire [`STATE_W-1:0] state_now,
    input wire [`STATE_W-1:0] state_prev,
    input wire rising,
    input wire first_cycle,
    // clear on read or clear-status
    input wire clear,
    // mask write
    input wire mask_wr,
    input wire [`STATE_W-1:0] mask_wdata,
    // results
    output reg [`STATE_W-1:0] latch_q,
    output reg [`STATE_W-1:0] mask_q,
    output wire summary
);

    wire [`STATE_W-1:0] edge_seen;
    reg [`STATE_W-1:0] latch_d;

    // watched edge from previous vs current word; suppressed on the first sampled cycle
    assign edge_seen = first_cycle ? {`STATE_W{1'b0}} :
                       (rising ? (state_now & ~state_prev) : (~state_now & state_prev));

    // new edges win over a clear in the same cycle so none is lost
    always @* begin
        latch_d = clear ? edge_seen : (latch_q | edge_seen);
    end

    always @(posedge clk) begin
        if (rst) begin
            latch_q <= `CHG_RST;
            mask_q <= `CHG_RST;
        end else begin
            latch_q <= latch_d;
            if (mask_wr) begin
                mask_q <= mask_wdata;
            end
        end
    end

    // mask applies only to this latch's summary contribution, bit for bit
    assign summary = |(latch_q & mask_q);

endmodule

/* design/status_change_event_regs.v */
`timescale 1ns/10ps
`include "status_change_defines.vh"

module status_change_event_regs (
    // clock and reset
    input wire clk,
    input wire rst,
    // instrument side
    input wire [`STATE_W-1:0] instrument_state_word,
    input wire power_cycled,
    input wire cmd_error,
    input wire exec_error,
    input wire dev_error,
    input wire query_error,
    input wire op_complete,
    // command port from the remote interface parser
    input wire rd_req,
    input wire wr_req,
    input wire [2:0] reg_sel,
    input wire [`STATE_W-1:0] wr_data,
    input wire clear_status,
    // answers
    output reg [`STATE_W-1:0] rd_data_q,
    output reg rd_valid_q,
    output wire change_summary_bit,
    output wire event_summary_bit
);

    ////////////////////////////////////////////////////////////////////////////
    // state word history

    reg [`STATE_W-1:0] state_prev_q;
    reg primed_q;

    // first cycle after reset has no valid history, so no edge is reported then
    always @(posedge clk) begin
        if (rst) begin
            state_prev_q <= `CHG_RST;
            primed_q <= 1'b0;
        end else begin
            state_prev_q <= instrument_state_word;
            primed_q <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // change latches

    function sel_hit;
        input [2:0] sel;
        input [2:0] want;
        begin
            sel_hit = (sel == want);
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // command decode

    wire rd_fall_latch;
    wire rd_rise_latch;
    wire rd_evt_status;
    wire wr_fall_mask;
    wire wr_rise_mask;
    wire wr_evt_enable;

    // reads that also clear; a read and a clear-status in one cycle act as one clear
    assign rd_fall_latch = rd_req & sel_hit(reg_sel, `SEL_FALL_LATCH);
    assign rd_rise_latch = rd_req & sel_hit(reg_sel, `SEL_RISE_LATCH);
    assign rd_evt_status = rd_req & sel_hit(reg_sel, `SEL_EVT_STATUS);

    // writes to selects without a writable register fall through and are ignored
    assign wr_fall_mask = wr_req & sel_hit(reg_sel, `SEL_FALL_MASK);
    assign wr_rise_mask = wr_req & sel_hit(reg_sel, `SEL_RISE_MASK);
    assign wr_evt_enable = wr_req & sel_hit(reg_sel, `SEL_EVT_ENABLE);

    wire fall_clear;
    wire rise_clear;
    wire [`STATE_W-1:0] fall_latch_q;
    wire [`STATE_W-1:0] rise_latch_q;
    wire [`STATE_W-1:0] fall_mask_q;
    wire [`STATE_W-1:0] rise_mask_q;
    wire fall_summary;
    wire rise_summary;

    // read zeroes the latch; same-cycle edges still survive inside the latch
    assign fall_clear = clear_status | rd_fall_latch;
    assign rise_clear = clear_status | rd_rise_latch;

    // one bit order shared by the word, both latches and both masks
    change_latch falling_change_latch (
        .clk(clk),
        .rst(rst),
        .state_now(instrument_state_word),
        .state_prev(state_prev_q),
        .rising(1'b0),
        .first_cycle(~primed_q),
        .clear(fall_clear),
        .mask_wr(wr_fall_mask),
        .mask_wdata(wr_data),
        .latch_q(fall_latch_q),
        .mask_q(fall_mask_q),
        .summary(fall_summary)
    );

    change_latch rising_change_latch (
        .clk(clk),
        .rst(rst),
        .state_now(instrument_state_word),
        .state_prev(state_prev_q),
        .rising(1'b1),
        .first_cycle(~primed_q),
        .clear(rise_clear),
        .mask_wr(wr_rise_mask),
        .mask_wdata(wr_data),
        .latch_q(rise_latch_q),
        .mask_q(rise_mask_q),
        .summary(rise_summary)
    );

    // zero masks give zero summaries, so the bit can never rise
    assign change_summary_bit = fall_summary | rise_summary;

    ////////////////////////////////////////////////////////////////////////////
    // standard event status and enable

    reg [`EVENT_W-1:0] evt_status_q;
    reg [`EVENT_W-1:0] evt_status_d;
    reg [`EVENT_W-1:0] evt_enable_q;
    reg [`EVENT_W-1:0] evt_set;
    wire evt_clear;

    assign evt_clear = clear_status | rd_evt_status;

    // gather events into the shared layout
    always @* begin
        evt_set = 8'h00;
        evt_set[`EVT_POWER_ON] = power_cycled;
        evt_set[`EVT_CMD_ERR] = cmd_error;
        evt_set[`EVT_EXEC_ERR] = exec_error;
        evt_set[`EVT_DEV_ERR] = dev_error;
        evt_set[`EVT_QUERY_ERR] = query_error;
        evt_set[`EVT_OP_DONE] = op_complete;
    end

    // sticky bits; a set in the clearing cycle wins so the event is kept
    always @* begin
        evt_status_d = (evt_clear ? 8'h00 : evt_status_q) | evt_set;
    end

    // status keeps only implemented bits, so 6 and 1 can never be seen set
    always @(posedge clk) begin
        if (rst) begin
            evt_status_q <= `EVT_RST;
        end else begin
            evt_status_q <= evt_status_d & `EVT_IMPL_MASK;
        end
    end

    // enable is written whole; unimplemented bits are dropped on the way in
    always @(posedge clk) begin
        if (rst) begin
            evt_enable_q <= `EVT_EN_RST;
        end else if (wr_evt_enable) begin
            evt_enable_q <= wr_data[`EVENT_W-1:0] & `EVT_IMPL_MASK;
        end
    end

    assign event_summary_bit = |(evt_status_q & evt_enable_q);

    ////////////////////////////////////////////////////////////////////////////
    // read-back

    reg [`STATE_W-1:0] rd_mux;

    // values are pre-clear snapshots; unknown selects return zero
    always @* begin
        case (reg_sel)
            `SEL_STATE: rd_mux = instrument_state_word;
            `SEL_FALL_LATCH: rd_mux = fall_latch_q;
            `SEL_RISE_LATCH: rd_mux = rise_latch_q;
            `SEL_FALL_MASK: rd_mux = fall_mask_q;
            `SEL_RISE_MASK: rd_mux = rise_mask_q;
            `SEL_EVT_STATUS: rd_mux = {8'h00, evt_status_q};
            `SEL_EVT_ENABLE: rd_mux = {8'h00, evt_enable_q};
            default: rd_mux = 16'h0000;
        endcase
    end

    // answer strobe lands one clock after the request and stays up for as many cycles as the request did
    always @(posedge clk) begin
        if (rst) begin
            rd_valid_q <= 1'b0;
        end else begin
            rd_valid_q <= rd_req;
        end
    end

    // data holds until the next read so a slow parser can still pick it up
    always @(posedge clk) begin
        if (rst) begin
            rd_data_q <= 16'h0000;
        end else if (rd_req) begin
            rd_data_q <= rd_mux;
        end
    end

endmodule

/* inc/status_change_defines.vh */
`ifndef STATUS_CHANGE_DEFINES_VH
`define STATUS_CHANGE_DEFINES_VH

// widths
`define STATE_W 16
`define EVENT_W 8

// standard event status bit positions
`define EVT_POWER_ON 7
`define EVT_CMD_ERR 5
`define EVT_EXEC_ERR 4
`define EVT_DEV_ERR 3
`define EVT_QUERY_ERR 2
`define EVT_OP_DONE 0

// implemented event bits; 6 and 1 always read zero
`define EVT_IMPL_MASK 8'hbd

// reset values
`define EVT_RST 8'h00
`define EVT_EN_RST 8'h00
`define CHG_RST 16'h0000

// register selects for the command port
`define SEL_STATE 3'h0
`define SEL_FALL_LATCH 3'h1
`define SEL_RISE_LATCH 3'h2
`define SEL_FALL_MASK 3'h3
`define SEL_RISE_MASK 3'h4
`define SEL_EVT_STATUS 3'h5
`define SEL_EVT_ENABLE 3'h6

`endif

/* verification/remote_ctl.sv */
`timescale 1ns/10ps
module remote_ctl (
    // clock
    input wire clk,
    // answers
    input wire [15:0] rd_data_q,
    input wire rd_valid_q,
    // command port
    output reg rd_req,
    output reg wr_req,
    output reg [2:0] reg_sel,
    output reg [15:0] wr_data,
    output reg clear_status
);
// idle command port at time zero
initial begin
    {rd_req, wr_req, clear_status, reg_sel, wr_data} = 22'h0;
end
// data flipped after a write so nothing leans on a stale bus
task wr(input [2:0] s, input [15:0] d);
    begin
        @(negedge clk) {wr_req, reg_sel, wr_data} = {1'b1, s, d};
        @(negedge clk) {wr_req, wr_data} = {1'b0, ~d};
    end
endtask
// answer is taken while its valid pulse stands; a missing pulse yields unknown data
task rd(input [2:0] s, output [15:0] d);
    begin
        @(negedge clk) {rd_req, reg_sel} = {1'b1, s};
        @(negedge clk) rd_req = 1'b0;
        d = rd_valid_q ? rd_data_q : 16'hxxxx;
    end
endtask
task cls;
    begin
        @(negedge clk) clear_status = 1'b1;
        @(negedge clk) clear_status = 1'b0;
    end
endtask
endmodule

/* verification/status_change_event_regs_tb.sv */
`timescale 1ns/10ps
module status_change_event_regs_tb;
reg clk, rst;
reg [7:0] ev;
reg [15:0] instrument_state_word, d;
wire power_cycled = ev[7], cmd_error = ev[5], exec_error = ev[4], dev_error = ev[3], query_error = ev[2];
wire op_complete = ev[0];
wire rd_req, wr_req, clear_status, rd_valid_q, change_summary_bit, event_summary_bit;
wire [2:0] reg_sel;
wire [15:0] wr_data, rd_data_q;
integer fails, n_compared, cyc, i;
status_change_event_regs dut (.*);
remote_ctl ctl (.*);
////////////////////////////////////////////////////////////////
initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
end
// hang guard, far above the roughly 80 cycles the tests need
always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 4000) begin
        fails = fails + 1;
        give_verdict;
    end
end
task chk(input [15:0] g, input [15:0] e);
    begin
        n_compared = n_compared + 1;
        if (g !== e) begin
            fails = fails + 1;
            $display("Error at %0t: got %h want %h", $time, g, e);
        end
    end
endtask
task rchk(input [2:0] s, input [15:0] e);
    begin
        ctl.rd(s, d);
        chk(d, e);
    end
endtask
// one cycle of event inputs
task evp(input [7:0] v);
    begin
        @(negedge clk) ev = v;
        @(negedge clk) ev = 8'h00;
    end
endtask
task sett(input [15:0] v);
    begin
        @(negedge clk) instrument_state_word = v;
        @(negedge clk);
    end
endtask
task give_verdict;
    begin
        $display("compared %0d fails %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    end
endtask
////////////////////////////////////////////////////////////////
initial begin
    {rst, ev, instrument_state_word, fails, n_compared, cyc} = {1'b1, 24'h0, 96'h0};
    repeat (2) @(negedge clk);
    rst = 1'b0;
    for (i = 0; i < 8; i = i + 1) rchk(i[2:0], 16'h0000);
    $display("test 1 done");
    ctl.wr(3'h3, 16'h00f0);
    ctl.wr(3'h4, 16'h0f00);
    ctl.wr(3'h6, 16'hffff);
    ctl.wr(3'h1, 16'hffff);
    rchk(3'h3, 16'h00f0);
    rchk(3'h4, 16'h0f00);
    rchk(3'h6, 16'h00bd);
    rchk(3'h1, 16'h0000);
    $display("test 2 done");
    sett(16'h0810);
    chk({15'h0, change_summary_bit}, 16'h0001);
    rchk(3'h0, 16'h0810);
    rchk(3'h2, 16'h0810);
    rchk(3'h2, 16'h0000);
    sett(16'h0010);
    chk({15'h0, change_summary_bit}, 16'h0000);
    sett(16'h0000);
    chk({15'h0, change_summary_bit}, 16'h0001);
    rchk(3'h1, 16'h0810);
    $display("test 3 done");
    ctl.wr(3'h3, 16'h0000);
    ctl.wr(3'h4, 16'h0000);
    sett(16'hffff);
    sett(16'h0000);
    chk({15'h0, change_summary_bit}, 16'h0000);
    rchk(3'h2, 16'hffff);
    evp(8'hbd);
    chk({15'h0, event_summary_bit}, 16'h0001);
    rchk(3'h5, 16'h00bd);
    rchk(3'h5, 16'h0000);
    evp(8'h20);
    ctl.cls;
    rchk(3'h5, 16'h0000);
    rchk(3'h1, 16'h0000);
    $display("test 4 done");
    // an event in the clear-status cycle must survive the clear
    fork
        evp(8'h01);
        ctl.cls;
    join
    rchk(3'h5, 16'h0001);
    // an edge seen in the cycle its latch is read must survive the read
    fork
        sett(16'h0001);
        rchk(3'h2, 16'h0000);
    join
    rchk(3'h2, 16'h0001);
    $display("test 5 done");
    give_verdict;
end
endmodule

/* verification/status_chk.sv */
`timescale 1ns/10ps
`include "status_change_defines.vh"
module status_chk (
    // clock and reset
    input wire clk,
    input wire rst,
    // instrument side
    input wire [`STATE_W-1:0] instrument_state_word,
    input wire power_cycled,
    input wire cmd_error,
    input wire exec_error,
    input wire dev_error,
    input wire query_error,
    input wire op_complete,
    // command port
    input wire rd_req,
    input wire wr_req,
    input wire [2:0] reg_sel,
    input wire [`STATE_W-1:0] wr_data,
    input wire clear_status,
    // answers
    input wire [`STATE_W-1:0] rd_data_q,
    input wire rd_valid_q,
    input wire change_summary_bit,
    input wire event_summary_bit
);
reg [15:0] fm_q, rm_q;
reg [7:0] ee_q;
wire [7:0] ev_w = {power_cycled, 1'b0, cmd_error, exec_error, dev_error, query_error, 1'b0, op_complete};
default clocking cb @(posedge clk); endclocking
default disable iff (rst);
////////////////////////////////////////////////////////////////
// mirror of the writable masks, so summaries can be judged
always @(posedge clk) begin
    if (rst) begin
        fm_q <= 16'h0000;
        rm_q <= 16'h0000;
        ee_q <= 8'h00;
    end else if (wr_req) begin
        if (reg_sel == `SEL_FALL_MASK) fm_q <= wr_data;
        if (reg_sel == `SEL_RISE_MASK) rm_q <= wr_data;
        if (reg_sel == `SEL_EVT_ENABLE) ee_q <= wr_data[7:0] & `EVT_IMPL_MASK;
    end
end
////////////////////////////////////////////////////////////////
rd_pulse_a: assert property (rd_valid_q == $past(rd_req)) else $error("read answer misplaced");
rd_hold_a: assert property (!rd_valid_q |-> $stable(rd_data_q)) else $error("read data moved");
state_read_a: assert property (rd_valid_q && $past(reg_sel) == `SEL_STATE
    |-> rd_data_q == $past(instrument_state_word)) else $error("state read wrong");
evt_bits_a: assert property (rd_valid_q && $past(reg_sel) > 3'h4
    |-> (rd_data_q & 16'hff42) == 16'h0000) else $error("unused event bits set");
no_mask_sum_a: assert property (fm_q == 16'h0000 && rm_q == 16'h0000
    |-> !change_summary_bit) else $error("summary without mask");
rise_sets_a: assert property (|(rm_q & instrument_state_word & ~$past(instrument_state_word))
    |=> change_summary_bit) else $error("rise not summarised");
fall_sets_a: assert property (|(fm_q & ~instrument_state_word & $past(instrument_state_word))
    |=> change_summary_bit) else $error("fall not summarised");
evt_sum_a: assert property (|(ev_w & ee_q) |=> event_summary_bit) else $error("event not summarised");
endmodule
bind status_change_event_regs status_chk chk_i (.*);
